//--- src/spm_top.sv
// Sleep power manager: sleep modes, timed detector shutdown, peripheral clock gating
`include "spm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module spm_top
    import spm_pkg::*;
#(
    parameter int OSC_STARTUP_CYC = 6
) (
    // Clock, reset, enable
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic        CE,
    // AXI4-Lite slave
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // Core
    input  wire logic        SLEEP_EXEC,
    input  wire logic        IRQ_PENDING,
    input  wire logic        ADC_DONE_IRQ,
    // Asynchronous wake sources
    input  wire logic        EXT_IRQ_ZERO_LVL,
    input  wire logic        PIN_CHANGE_IRQ,
    input  wire logic        WDT_RESET_REQ,
    input  wire logic        BOD_RESET_REQ,
    // Configuration from other blocks
    input  wire logic        XTAL_CLOCK_SEL,
    input  wire logic        BROWNOUT_LEVEL_FUSE_EN,
    input  wire logic        ADC_ENABLE,
    input  wire logic        ADC_CONV_START,
    input  wire logic        ACOMP_ENABLE,
    input  wire logic        ACOMP_USE_VREF,
    input  wire logic        WDT_ENABLE,
    // Clock enables
    output logic             CPU_CLK_EN,
    output logic             FLASH_CLK_EN,
    output logic             IO_CLK_EN,
    output logic             ADC_CLK_EN,
    output logic             OSC_EN,
    output logic [3:0]       PERIPH_CLK_EN,
    output logic [3:0]       PERIPH_ACCESS_EN,
    // Analog and misc control
    output logic             BROWNOUT_DETECTOR_EN,
    output logic             ACOMP_EN,
    output logic             ADC_RUN,
    output logic             ADC_EXTENDED_CONV,
    output logic             VREF_EN,
    output logic             WDT_RUN,
    output logic             INPUT_BUF_EN,
    output logic             PULLUP_GLOBAL_OFF,
    output logic [1:0]       EXT_IRQ_SENSE
);
    localparam int BOD_WAKE_CYC = `SPM_BOD_WAKE_US * `SPM_REF_CLK_MHZ;
    localparam logic [2:0] BRS_TOTAL = 3'(`SPM_BRS_DELAY_CYC + `SPM_BRS_HOLD_CYC);
    localparam logic [2:0] BRS_HOLD = 3'(`SPM_BRS_HOLD_CYC);

    spm_state_s r;
    spm_state_s n;
    logic [3:0] wake_src;
    logic       wr_en;
    logic [7:0] wr_data;
    logic       brs_eff;
    logic       deep;
    logic       io_on;
    logic       adc_on;
    logic [10:0] start_cyc;

    spm_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk      (REF_CLK),
        .rst_n    (RSTN),
        .ce       (CE),
        .async_in ({BOD_RESET_REQ, WDT_RESET_REQ, PIN_CHANGE_IRQ, EXT_IRQ_ZERO_LVL}),
        .sync_out (wake_src)
    );

    function automatic logic [7:0] idx_addr(input logic [7:0] idx);
        idx_addr = {idx[5:0], 2'h0};
    endfunction : idx_addr

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == idx_addr(`SPM_IDX_MCU_POWER_CONTROL))
                || (a == idx_addr(`SPM_IDX_PERIPH_GATE))
                || (a == idx_addr(`SPM_IDX_SLEEP_STATUS));
    endfunction : addr_hit

    function automatic spm_mode_e decode_mode(input logic [1:0] sm, input logic xtal);
        unique case (sm)
            2'h0: decode_mode = SPM_IDLE;
            2'h1: decode_mode = SPM_CONV_NR;
            2'h2: decode_mode = SPM_POWER_DOWN;
            2'h3: decode_mode = xtal ? SPM_STANDBY : SPM_POWER_DOWN;
        endcase
    endfunction : decode_mode

    function automatic logic is_deep(input spm_mode_e m);
        is_deep = (m == SPM_POWER_DOWN) || (m == SPM_STANDBY);
    endfunction : is_deep

    always_comb begin
        n       = r;
        wr_en   = 1'b0;
        wr_data = r.w_data;
        brs_eff = (r.brs_cnt != 3'h0) && (r.brs_cnt <= BRS_HOLD);
        start_cyc = 11'h000;

        // Write channel capture, address and data in either order
        if (AWVALID && r.awready) begin
            n.aw_full = 1'b1;
            n.aw_addr = AWADDR;
        end
        if (WVALID && r.wready) begin
            n.w_full = 1'b1;
            n.w_data = WDATA[7:0];
            n.w_strb = WSTRB[0];
        end
        if (BREADY && r.bvalid) begin
            n.bvalid = 1'b0;
        end
        if (n.aw_full && n.w_full && !n.bvalid) begin
            wr_en   = n.w_strb && addr_hit(n.aw_addr);
            wr_data = n.w_data;
            n.bvalid = 1'b1;
            n.bresp  = addr_hit(n.aw_addr) ? `SPM_RESP_OKAY : `SPM_RESP_SLVERR;
            n.aw_full = 1'b0;
            n.w_full  = 1'b0;
        end
        n.awready = !n.aw_full;
        n.wready  = !n.w_full;

        // Read channel
        if (RREADY && r.rvalid) begin
            n.rvalid = 1'b0;
        end
        if (ARVALID && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = addr_hit(ARADDR) ? `SPM_RESP_OKAY : `SPM_RESP_SLVERR;
            n.rdata  = 8'h00;
            if (ARADDR == idx_addr(`SPM_IDX_MCU_POWER_CONTROL)) begin
                n.rdata[`SPM_BIT_BRS_OFF]    = r.brs_cnt != 3'h0;
                n.rdata[`SPM_BIT_PULLUP_OFF] = r.pullup_off;
                n.rdata[`SPM_BIT_SLEEP_EN]   = r.sleep_en;
                n.rdata[`SPM_BIT_MODE_HI]    = r.sm[1];
                n.rdata[`SPM_BIT_MODE_LO]    = r.sm[0];
                n.rdata[`SPM_BIT_BRS_UNLOCK] = r.unlock_cnt != 3'h0;
                n.rdata[`SPM_BIT_SENSE_HI]   = r.sense[1];
                n.rdata[`SPM_BIT_SENSE_LO]   = r.sense[0];
            end else if (ARADDR == idx_addr(`SPM_IDX_PERIPH_GATE)) begin
                n.rdata[3:0] = r.gate;
            end else if (ARADDR == idx_addr(`SPM_IDX_SLEEP_STATUS)) begin
                n.rdata[`SPM_BIT_ST_SLEEP]   = r.fsm == SPM_SLEEP;
                n.rdata[`SPM_BIT_ST_WAKING]  = r.fsm == SPM_WAKE;
                n.rdata[`SPM_BIT_ST_BOD_OFF] = r.bod_off;
                n.rdata[`SPM_BIT_ST_INBUF]   = r.inbuf_on;
                n.rdata[`SPM_BIT_ST_MODE_LO +: 2] = r.mode;
            end
        end
        n.arready = !n.rvalid;

        // unlock window and off-bit lifetime count down
        if (r.unlock_cnt != 3'h0) begin
            n.unlock_cnt = r.unlock_cnt - 3'h1;
        end
        if (r.brs_cnt != 3'h0) begin
            n.brs_cnt = r.brs_cnt - 3'h1;
        end

        if (wr_en && (n.aw_addr == idx_addr(`SPM_IDX_MCU_POWER_CONTROL))) begin
            n.pullup_off = wr_data[`SPM_BIT_PULLUP_OFF];
            n.sleep_en   = wr_data[`SPM_BIT_SLEEP_EN];
            n.sm         = {wr_data[`SPM_BIT_MODE_HI], wr_data[`SPM_BIT_MODE_LO]};
            n.sense      = {wr_data[`SPM_BIT_SENSE_HI], wr_data[`SPM_BIT_SENSE_LO]};
            if (wr_data[`SPM_BIT_BRS_OFF] && wr_data[`SPM_BIT_BRS_UNLOCK]) begin
                n.unlock_cnt = 3'(`SPM_UNLOCK_CYC);
            end else if (wr_data[`SPM_BIT_BRS_OFF] && (r.unlock_cnt != 3'h0)) begin
                n.brs_cnt    = BRS_TOTAL;
                n.unlock_cnt = 3'h0;
            end else if (!wr_data[`SPM_BIT_BRS_OFF]) begin
                n.brs_cnt = 3'h0;
            end
            // off without unlock leaves the off-bit count unchanged
        end
        if (wr_en && (n.aw_addr == idx_addr(`SPM_IDX_PERIPH_GATE))) begin
            n.gate = wr_data[3:0];
        end

        unique case (r.fsm)
            SPM_ACTIVE: begin
                if (SLEEP_EXEC && r.sleep_en) begin
                    n.fsm  = SPM_SLEEP;
                    n.mode = decode_mode(r.sm, XTAL_CLOCK_SEL);
                    n.bod_off = brs_eff && is_deep(decode_mode(r.sm, XTAL_CLOCK_SEL));
                end
            end
            SPM_SLEEP: begin
                if (is_deep(r.mode)) begin
                    start_cyc = (r.mode == SPM_STANDBY) ? 11'(`SPM_STANDBY_WAKE_CYC)
                                                        : 11'(OSC_STARTUP_CYC);
                end
                // detector must settle before code runs
                if (r.bod_off && (start_cyc < 11'(BOD_WAKE_CYC))) begin
                    start_cyc = 11'(BOD_WAKE_CYC);
                end
                if (wake_src[3] || wake_src[2]) begin
                    n.fsm      = SPM_WAKE;
                    n.wake_cnt = start_cyc;
                end else if (wake_src[1] || wake_src[0]
                             || ((r.mode == SPM_CONV_NR) && ADC_DONE_IRQ)
                             || ((r.mode == SPM_IDLE) && IRQ_PENDING)) begin
                    n.fsm = SPM_WAKE;
                    n.wake_cnt = start_cyc + 11'(`SPM_IRQ_HALT_CYC);
                end
            end
            SPM_WAKE: begin
                if (r.wake_cnt <= 11'h001) begin
                    n.fsm      = SPM_ACTIVE;
                    n.wake_cnt = 11'h000;
                    n.bod_off  = 1'b0;
                end else begin
                    n.wake_cnt = r.wake_cnt - 11'h001;
                end
            end
            default: begin
                n.fsm = SPM_ACTIVE;
            end
        endcase

        // deep is set in every sleep mode; only power-down stops every generated clock
        deep   = n.fsm == SPM_SLEEP;
        // idle keeps I/O and converter clocks
        // noise reduction keeps only the converter clock
        io_on  = !deep || (n.mode == SPM_IDLE);
        adc_on = !deep || (n.mode == SPM_IDLE) || (n.mode == SPM_CONV_NR);
        n.cpu_clk   = n.fsm == SPM_ACTIVE;
        n.flash_clk = n.fsm == SPM_ACTIVE;
        n.io_clk    = io_on;
        n.adc_clk   = adc_on;
        n.osc_en    = !deep || (n.mode != SPM_POWER_DOWN);
        // gating matters only while the domain clock runs
        // clearing a bit simply restores the clock
        n.periph_clk = {io_on, io_on, io_on, adc_on} & ~n.gate;
        n.periph_acc = ~n.gate;
        n.bod_on   = BROWNOUT_LEVEL_FUSE_EN && !(deep && n.bod_off);
        n.acomp_on = ACOMP_ENABLE && adc_on;
        n.adc_run  = ADC_ENABLE;
        n.adc_en_d = ADC_ENABLE;
        if (ADC_CONV_START) begin
            n.adc_ext = 1'b0;
        end
        // re-enable flags an extended conversion; set beats clear
        if (ADC_ENABLE && !r.adc_en_d) begin
            n.adc_ext = 1'b1;
        end
        n.vref_on  = n.bod_on || (ACOMP_ENABLE && ACOMP_USE_VREF) || ADC_ENABLE;
        n.wdt_run  = WDT_ENABLE;
        // buffers off when both clocks stop
        n.inbuf_on = io_on || adc_on;
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            r <= '0;
        end else if (CE) begin
            r <= n;
        end
    end

    assign AWREADY              = r.awready;
    assign WREADY               = r.wready;
    assign BVALID               = r.bvalid;
    assign BRESP                = r.bresp;
    assign ARREADY              = r.arready;
    assign RVALID               = r.rvalid;
    assign RRESP                = r.rresp;
    assign RDATA                = {24'h000000, r.rdata};
    assign CPU_CLK_EN           = r.cpu_clk;
    assign FLASH_CLK_EN         = r.flash_clk;
    assign IO_CLK_EN            = r.io_clk;
    assign ADC_CLK_EN           = r.adc_clk;
    assign OSC_EN               = r.osc_en;
    assign PERIPH_CLK_EN        = r.periph_clk;
    assign PERIPH_ACCESS_EN     = r.periph_acc;
    assign BROWNOUT_DETECTOR_EN = r.bod_on;
    assign ACOMP_EN             = r.acomp_on;
    assign ADC_RUN              = r.adc_run;
    assign ADC_EXTENDED_CONV    = r.adc_ext;
    assign VREF_EN              = r.vref_on;
    assign WDT_RUN              = r.wdt_run;
    assign INPUT_BUF_EN         = r.inbuf_on;
    assign PULLUP_GLOBAL_OFF    = r.pullup_off;
    assign EXT_IRQ_SENSE        = r.sense;
endmodule : spm_top
`default_nettype wire

//--- src/spm_regs.svh
// Register map, field positions, reset values and timing counts of the sleep power manager
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

// Register indices; byte address is four times the index
`define SPM_IDX_MCU_POWER_CONTROL 8'h35
`define SPM_IDX_PERIPH_GATE       8'h00
`define SPM_IDX_SLEEP_STATUS      8'h36

// mcu_power_control fields
`define SPM_BIT_BRS_OFF    7
`define SPM_BIT_PULLUP_OFF 6
`define SPM_BIT_SLEEP_EN   5
`define SPM_BIT_MODE_HI    4
`define SPM_BIT_MODE_LO    3
`define SPM_BIT_BRS_UNLOCK 2
`define SPM_BIT_SENSE_HI   1
`define SPM_BIT_SENSE_LO   0
`define SPM_RST_MCU_POWER_CONTROL 8'h00

// peripheral_clock_gate_reg fields
`define SPM_BIT_TIMER1_GATE 3
`define SPM_BIT_TIMER0_GATE 2
`define SPM_BIT_USI_GATE    1
`define SPM_BIT_CONV_GATE   0
`define SPM_RST_PERIPH_GATE 8'h00

// sleep status fields
`define SPM_BIT_ST_SLEEP   0
`define SPM_BIT_ST_WAKING  1
`define SPM_BIT_ST_BOD_OFF 2
`define SPM_BIT_ST_INBUF   3
`define SPM_BIT_ST_MODE_LO 4

// Bus responses
`define SPM_RESP_OKAY   2'h0
`define SPM_RESP_SLVERR 2'h2

// Timing
`define SPM_REF_CLK_MHZ      20
`define SPM_UNLOCK_CYC       4
`define SPM_BRS_DELAY_CYC    3
`define SPM_BRS_HOLD_CYC     3
`define SPM_STANDBY_WAKE_CYC 6
`define SPM_IRQ_HALT_CYC     4
`define SPM_BOD_WAKE_US      60

`endif

//--- src/spm_pkg.sv
// Types of the sleep power manager
package spm_pkg;

    typedef enum logic [1:0] {
        SPM_ACTIVE,
        SPM_SLEEP,
        SPM_WAKE
    } spm_fsm_e;

    typedef enum logic [1:0] {
        SPM_IDLE,
        SPM_CONV_NR,
        SPM_POWER_DOWN,
        SPM_STANDBY
    } spm_mode_e;

    typedef struct packed {
        spm_fsm_e   fsm;
        spm_mode_e  mode;
        logic       bod_off;
        logic [10:0] wake_cnt;
        logic [2:0] unlock_cnt;
        logic [2:0] brs_cnt;
        logic       pullup_off;
        logic       sleep_en;
        logic [1:0] sm;
        logic [1:0] sense;
        logic [3:0] gate;
        logic       adc_en_d;
        logic       adc_ext;
        logic       cpu_clk;
        logic       flash_clk;
        logic       io_clk;
        logic       adc_clk;
        logic       osc_en;
        logic [3:0] periph_clk;
        logic [3:0] periph_acc;
        logic       bod_on;
        logic       acomp_on;
        logic       adc_run;
        logic       vref_on;
        logic       wdt_run;
        logic       inbuf_on;
        logic       aw_full;
        logic [7:0] aw_addr;
        logic       w_full;
        logic [7:0] w_data;
        logic       w_strb;
        logic       awready;
        logic       wready;
        logic       bvalid;
        logic [1:0] bresp;
        logic       arready;
        logic       rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
    } spm_state_s;

endpackage : spm_pkg

//--- src/spm_sync.sv
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module spm_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_next;

    // A bit changes only once stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : sync_out[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            sync_out <= '0;
        end else if (ce) begin
            s1_reg   <= async_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            sync_out <= out_next;
        end
    end
endmodule : spm_sync
`default_nettype wire

//--- test/spm_core_model.sv
// Core stand-in that executes one sleep instruction per request
`timescale 1ns/1ps
`default_nettype none
module spm_core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Core clock gate and requests
    input  wire logic       cpu_clk_en,
    input  wire logic [7:0] req_cnt,
    output logic            sleep_exec
);
    logic [7:0] done_cnt;
    logic       fire;
    assign fire = cpu_clk_en && !sleep_exec && (done_cnt != req_cnt);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_exec <= 1'h0;
            done_cnt   <= 8'h00;
        end else begin
            sleep_exec <= fire;
            done_cnt   <= done_cnt + {7'h00, fire};
        end
    end
endmodule : spm_core_model
`default_nettype wire

//--- test/spm_top_properties.sv
// Port-level checks of the sleep power manager
`timescale 1ns/1ps
`default_nettype none
module spm_top_properties #(
    parameter int OSC_STARTUP_CYC = 6
) (
    // Clock and reset
    input wire logic       REF_CLK,
    input wire logic       RSTN,
    // Configuration
    input wire logic       XTAL_CLOCK_SEL,
    input wire logic       BROWNOUT_LEVEL_FUSE_EN,
    // Clock enables
    input wire logic       CPU_CLK_EN,
    input wire logic       FLASH_CLK_EN,
    input wire logic       IO_CLK_EN,
    input wire logic       ADC_CLK_EN,
    input wire logic       OSC_EN,
    input wire logic [3:0] PERIPH_CLK_EN,
    input wire logic [3:0] PERIPH_ACCESS_EN,
    // Analog control
    input wire logic       BROWNOUT_DETECTOR_EN,
    input wire logic       ACOMP_EN,
    input wire logic       INPUT_BUF_EN
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    logic [11:0] wake_cnt;
    logic        bde_d;
    // Too long for a delay range, so the wake is timed here
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wake_cnt <= 12'h000;
            bde_d    <= 1'h0;
        end else begin
            bde_d <= BROWNOUT_DETECTOR_EN;
            if (CPU_CLK_EN)
                wake_cnt <= 12'h000;
            else if (wake_cnt != 12'h000
                     || (BROWNOUT_LEVEL_FUSE_EN && BROWNOUT_DETECTOR_EN && !bde_d))
                wake_cnt <= wake_cnt + 12'h001;
        end
    end
    sequence s_stby_wake;
        $rose(IO_CLK_EN) && !CPU_CLK_EN && $past(OSC_EN) && !$past(ADC_CLK_EN);
    endsequence
    sequence s_cpu_back;
        !CPU_CLK_EN [*5] ##[1:8] CPU_CLK_EN;
    endsequence
    a_cpu_flash_pair: assert property (CPU_CLK_EN == FLASH_CLK_EN
        && (!CPU_CLK_EN || (IO_CLK_EN && ADC_CLK_EN && OSC_EN)))
        else $error("Clock enables inconsistent with running CPU");
    a_inbuf_deep: assert property (!IO_CLK_EN && !ADC_CLK_EN |-> !INPUT_BUF_EN)
        else $error("Input buffers on with I/O and converter clocks stopped");
    a_osc_stop: assert property (!ADC_CLK_EN && !CPU_CLK_EN && !XTAL_CLOCK_SEL |-> !OSC_EN)
        else $error("Oscillator runs in deep sleep without crystal");
    a_acomp_off: assert property (!ADC_CLK_EN |-> !ACOMP_EN)
        else $error("Comparator left on in deep sleep");
    // Active mode runs every domain, so only the gate bits decide
    a_gate_access: assert property ((PERIPH_CLK_EN & ~PERIPH_ACCESS_EN) == 4'h0
        && (!CPU_CLK_EN || PERIPH_CLK_EN == PERIPH_ACCESS_EN))
        else $error("Gated peripheral clock and access disagree");
    a_fuse_bod_on: assert property (BROWNOUT_LEVEL_FUSE_EN && $past(BROWNOUT_LEVEL_FUSE_EN)
        && !BROWNOUT_DETECTOR_EN |-> !CPU_CLK_EN && !ADC_CLK_EN)
        else $error("Fuse-enabled detector off outside deep sleep");
    a_standby_wake: assert property (s_stby_wake |-> s_cpu_back)
        else $error("Standby wake time wrong");
    a_bod_wake_time: assert property ($rose(CPU_CLK_EN) && wake_cnt != 12'h000
        |-> wake_cnt >= 12'h4AB && wake_cnt <= 12'h4BF)
        else $error("Wake after detector shutdown not stretched");
endmodule : spm_top_properties
bind spm_top spm_top_properties #(.OSC_STARTUP_CYC(OSC_STARTUP_CYC)) spm_top_properties_inst (.*);
`default_nettype wire

//--- test/sleep_power_manager_tb.sv
// Self-checking bench of the sleep power manager
`timescale 1ns/1ps
`default_nettype none
module sleep_power_manager_tb;
    logic REF_CLK = 1'h0, RSTN = 1'h0, CE = 1'h1;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, req_cnt = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA, d;
    logic [3:0] WSTRB = 4'hF, PERIPH_CLK_EN, PERIPH_ACCESS_EN;
    logic [1:0] BRESP, RRESP, EXT_IRQ_SENSE, r;
    logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
    logic IRQ_PENDING = 1'h0, ADC_DONE_IRQ = 1'h0, EXT_IRQ_ZERO_LVL = 1'h0, PIN_CHANGE_IRQ = 1'h0;
    logic WDT_RESET_REQ = 1'h0, BOD_RESET_REQ = 1'h0, XTAL_CLOCK_SEL = 1'h1;
    logic BROWNOUT_LEVEL_FUSE_EN = 1'h0, ADC_ENABLE = 1'h0, ADC_CONV_START = 1'h0;
    logic ACOMP_ENABLE = 1'h1, ACOMP_USE_VREF = 1'h1, WDT_ENABLE = 1'h1;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SLEEP_EXEC, CPU_CLK_EN, FLASH_CLK_EN;
    logic IO_CLK_EN, ADC_CLK_EN, OSC_EN, BROWNOUT_DETECTOR_EN, ACOMP_EN, ADC_RUN, VREF_EN;
    logic ADC_EXTENDED_CONV, WDT_RUN, INPUT_BUF_EN, PULLUP_GLOBAL_OFF;
    int errors = 0, check_count = 0, n;
    // Short oscillator start-up keeps power-down wakes quick
    spm_top #(.OSC_STARTUP_CYC(2)) spm_top_inst (.*);
    spm_core_model spm_core_model_inst (.clk(REF_CLK), .rst_n(RSTN), .cpu_clk_en(CPU_CLK_EN),
        .req_cnt(req_cnt), .sleep_exec(SLEEP_EXEC));
    always #25 REF_CLK = ~REF_CLK;
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    task automatic timeout_hit();
        errors++;
        test_done();
    endtask : timeout_hit
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge REF_CLK);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int i;
        @(posedge REF_CLK);
        AWADDR  <= a;
        WDATA   <= v;
        AWVALID <= 1'h1;
        WVALID  <= 1'h1;
        BREADY  <= 1'h1;
        for (i = 0; i < 40; i++) begin
            @(posedge REF_CLK);
            if (AWREADY) AWVALID <= 1'h0;
            if (WREADY) WVALID <= 1'h0;
            if (BVALID) break;
        end
        r = BRESP;
        BREADY <= 1'h0;
        if (i == 40) timeout_hit();
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int i;
        @(posedge REF_CLK);
        ARADDR  <= a;
        ARVALID <= 1'h1;
        RREADY  <= 1'h1;
        for (i = 0; i < 40; i++) begin
            @(posedge REF_CLK);
            if (ARREADY) ARVALID <= 1'h0;
            if (RVALID) break;
        end
        d = RDATA;
        r = RRESP;
        RREADY <= 1'h0;
        if (i == 40) timeout_hit();
    endtask : rd
    task automatic slp();
        @(posedge REF_CLK);
        req_cnt <= req_cnt + 8'h01;
        tick(4);
    endtask : slp
    task automatic wcpu();
        for (n = 0; n < 3000 && CPU_CLK_EN !== 1'h1; n++) @(posedge REF_CLK);
        if (n == 3000) timeout_hit();
    endtask : wcpu
    task automatic t_regs();
        rd(8'hD4);
        chk("mcu_reset", 32'h0, d);
        rd(8'h00);
        chk("gate_reset", 32'h0, d);
        WSTRB <= 4'h0;
        wr(8'h00, 32'h0F);
        WSTRB <= 4'hF;
        rd(8'h00);
        chk("strb_off", 32'h0, d);
        wr(8'h00, 32'hFF);
        chk("wr_okay", 32'h0, r);
        rd(8'h00);
        chk("gate_upper", 32'h0F, d);
        chk("gate_all", 32'h0, {PERIPH_CLK_EN, PERIPH_ACCESS_EN});
        wr(8'h00, 32'h05);
        tick(1);
        chk("gate_part", 32'hAA, {PERIPH_CLK_EN, PERIPH_ACCESS_EN});
        wr(8'h00, 32'h00);
        tick(1);
        chk("gate_none", 32'hFF, {PERIPH_CLK_EN, PERIPH_ACCESS_EN});
        rd(8'h40);
        chk("unmapped", 32'h2, r);
        wr(8'h40, 32'hFF);
        chk("wr_unmapped", 32'h2, r);
        wr(8'hD4, 32'h43);
        tick(1);
        chk("misc_bits", 32'h7, {PULLUP_GLOBAL_OFF, EXT_IRQ_SENSE});
        wr(8'hD4, 32'h00);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_conv();
        ACOMP_ENABLE <= 1'h0;
        tick(4);
        chk("vref_off", 32'h0, VREF_EN);
        // Clock enable low must hold every output
        CE <= 1'h0;
        ADC_ENABLE <= 1'h1;
        tick(4);
        chk("ce_freeze", 32'h0, {VREF_EN, ADC_EXTENDED_CONV});
        CE <= 1'h1;
        tick(4);
        chk("vref_adc", 32'h3, {VREF_EN, ADC_EXTENDED_CONV});
        ADC_CONV_START <= 1'h1;
        tick(1);
        ADC_CONV_START <= 1'h0;
        tick(2);
        chk("ext_conv", 32'h0, ADC_EXTENDED_CONV);
        ACOMP_ENABLE <= 1'h1;
        $display("t_conv done");
    endtask : t_conv
    task automatic t_modes();
        logic [8:0] ex [4];
        logic [8:0] v;
        logic [7:0] wt [4];
        // Per mode: cpu, flash, io, adc, osc, buffers, converter, comparator, watchdog
        ex = '{9'h07F, 9'h03F, 9'h005, 9'h015};
        // Edges from wake request until the CPU clock is seen back
        wt = '{8'h0A, 8'h06, 8'h0C, 8'h10};
        for (int m = 0; m < 4; m++) begin
            XTAL_CLOCK_SEL <= (m == 3);
            wr(8'hD4, 32'h20 | (m << 3));
            slp();
            IRQ_PENDING <= (m > 1);
            ADC_DONE_IRQ <= (m > 1);
            tick(10);
            v = {CPU_CLK_EN, FLASH_CLK_EN, IO_CLK_EN, ADC_CLK_EN, OSC_EN, INPUT_BUF_EN,
                 ADC_RUN, ACOMP_EN, WDT_RUN};
            chk("sleep_mode", ex[m], v);
            rd(8'hD8);
            chk("status", 32'h1 | (m << 4) | (m < 2 ? 32'h8 : 32'h0), d);
            // Converter interrupt wakes noise reduction, the level input the others
            EXT_IRQ_ZERO_LVL <= (m != 1);
            ADC_DONE_IRQ <= 1'h1;
            wcpu();
            chk("wake_time", wt[m], n);
            EXT_IRQ_ZERO_LVL <= 1'h0;
            IRQ_PENDING <= 1'h0;
            ADC_DONE_IRQ <= 1'h0;
            wr(8'hD4, 32'h00);
        end
        wr(8'hD4, 32'h10);
        slp();
        chk("no_enable", 32'h1, CPU_CLK_EN);
        $display("t_modes done");
    endtask : t_modes
    task automatic t_bod();
        BROWNOUT_LEVEL_FUSE_EN <= 1'h1;
        wr(8'hD4, 32'hB4);
        wr(8'hD4, 32'hB0);
        rd(8'hD4);
        chk("off_live", 32'h1, d[7]);
        tick(8);
        rd(8'hD4);
        chk("off_gone", 32'h0, d[7]);
        wr(8'hD4, 32'hB0);
        slp();
        chk("bod_kept", 32'h1, BROWNOUT_DETECTOR_EN);
        PIN_CHANGE_IRQ <= 1'h1;
        wcpu();
        PIN_CHANGE_IRQ <= 1'h0;
        wr(8'hD4, 32'hB4);
        wr(8'hD4, 32'hB0);
        // Sleep must land in the late part of the off-bit life
        tick(1);
        slp();
        chk("bod_off", 32'h0, BROWNOUT_DETECTOR_EN);
        WDT_RESET_REQ <= 1'h1;
        wcpu();
        WDT_RESET_REQ <= 1'h0;
        chk("long_wake", 32'h1, n >= 1200);
        chk("bod_back", 32'h1, BROWNOUT_DETECTOR_EN);
        $display("t_bod done");
    endtask : t_bod
    initial begin
        tick(3);
        RSTN <= 1'h1;
        tick(2);
        t_regs();
        t_conv();
        t_modes();
        t_bod();
        test_done();
    end
endmodule : sleep_power_manager_tb
`default_nettype wire
